//--- testbench/dtd_line_rx.sv
// dtd_line_rx: line receiver model timing the slot steps of one tone pin
`timescale 1ns/1ps
`default_nettype none
module dtd_line_rx
	import dtd_pkg::*;
(
	input  wire logic             clk_sys, // system clock
	input  wire logic             arm,     // restart measurement
	input  wire logic [DAC_W-1:0] tone,    // tone pin as the line sees it
	output var int                span,    // clocks over four slot steps
	output logic                  seq_ok   // steps follow the sine order
);
	logic [DAC_W-1:0] last;
	int               n;
	int               t;
	always @(posedge clk_sys) begin
		last <= tone;
		t <= t + 1;
		if (arm) begin
			n <= 0;
			span <= 0;
			seq_ok <= 1'b1;
		end else if (tone != last && n < 5) begin
			n <= n + 1;
			if (tone !== SINE[n + 1])
				seq_ok <= 1'b0;
			if (n == 0)
				t <= 1;
			if (n == 4)
				span <= t;
		end
	end
endmodule
`default_nettype wire

//--- testbench/dual_tone_dialing_generator_tb.sv
// dual_tone_dialing_generator_tb: self-checking bench of the tone generator
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fails++; $display("BAD t=%0t %h %h", $time, g, e); end end
module dual_tone_dialing_generator_tb
	import dtd_pkg::*;
;
	logic             clk_sys, rst_b, osc_fast, cyc, stb, we, ack, arm;
	logic [11:0]      adr;
	logic [3:0]       sel;
	logic [31:0]      dat_i, dat_o, q, r;
	logic [DAC_W-1:0] row_pin, col_pin;
	int               fails, checks, rspan, cspan;
	logic             rok, cok, bad;

	dtd_top DUT (.clk_sys(clk_sys), .rst_b(rst_b), .osc_fast_pin(osc_fast), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_i),
		.wb_dat_o(dat_o), .wb_ack_o(ack), .row_tone_pin(row_pin), .column_tone_pin(col_pin));
	dtd_line_rx row_rx (.clk_sys(clk_sys), .arm(arm), .tone(row_pin), .span(rspan), .seq_ok(rok));
	dtd_line_rx col_rx (.clk_sys(clk_sys), .arm(arm), .tone(col_pin), .span(cspan), .seq_ok(cok));

	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end

	task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		int k;
		@(posedge clk_sys);
		{cyc, stb, we, adr, dat_i, sel} <= {2'b11, w, a, d, s};
		k = 0;
		do begin
			@(posedge clk_sys);
			k++;
		end while (ack !== 1'b1 && k < 50);
		q = dat_o;
		if (k >= 50) begin
			fails++;
			end_sim();
		end
		{cyc, stb, we} <= 3'b000;
	endtask

	// expected clocks over four slots: n ticks per cycle, 125/div clocks per tick
	function automatic int exp_span(int n, int div);
		return n * 1000 / (64 * div);
	endfunction

	function automatic logic near(int got, int e);
		return (got > e ? got - e : e - got) <= 140;
	endfunction

	task automatic tone(input logic [3:0] code, input logic rowon, input int div);
		int k;
		arm <= 1'b1;
		@(posedge clk_sys);
		arm <= 1'b0;
		wb(1'b1, 12'h040, {28'h0, code}, 4'hf);
		wb(1'b1, 12'h044, rowon ? 32'he : 32'ha, 4'hf);
		k = 0;
		while ((cspan == 0 || (rowon && rspan == 0)) && k < 20000) begin
			@(posedge clk_sys);
			k++;
		end
		if (k >= 20000) begin
			fails++;
			end_sim();
		end
		`CHK(near(cspan, exp_span(COL_LEN[code[3:2]], div)), 1'b1)
		`CHK(cok, 1'b1)
		if (rowon) begin
			`CHK(near(rspan, exp_span(ROW_LEN[code[1:0]], div)), 1'b1)
			`CHK(rok, 1'b1)
		end else
			`CHK(row_pin, DAC_IDLE)
		wb(1'b1, 12'h044, 32'h0, 4'hf);
		$display("test tone %h done", code);
	endtask

	task automatic end_sim();
		$display("checks=%0d fails=%0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial begin
		repeat (90000) @(posedge clk_sys);
		fails++;
		end_sim();
	end

	initial begin
		{rst_b, osc_fast, cyc, stb, we, adr, sel, dat_i, arm} = '0;
		fails = 0;
		checks = 0;
		void'($urandom(32'h3dbbfd7c));
		repeat (10) @(posedge clk_sys);
		rst_b <= 1'b1;
		`CHK({row_pin, col_pin}, {DAC_IDLE, DAC_IDLE})
		wb(1'b0, 12'h040, 32'h0, 4'hf);
		`CHK(q, 32'h0)
		wb(1'b0, 12'h044, 32'h0, 4'hf);
		`CHK(q, 32'h0)
		wb(1'b0, 12'h080, 32'h0, 4'hf);
		`CHK(q, 32'h0)
		wb(1'b0, 12'hffc, 32'h0, 4'hf);
		`CHK(q, 32'h0)
		$display("test reset done");
		repeat (8) begin
			r = $urandom;
			wb(1'b1, 12'h080, r, 4'hf);
			wb(1'b0, 12'h080, 32'h0, 4'hf);
			`CHK(q, r & 32'h4)
		end
		wb(1'b1, 12'h080, 32'h4, 4'he);
		wb(1'b0, 12'h080, 32'h0, 4'hf);
		`CHK(q, r & 32'h4)
		wb(1'b1, 12'h080, 32'h0, 4'hf);
		$display("test speed flag done");
		wb(1'b1, 12'h040, {28'h0, 4'($urandom)}, 4'hf);
		wb(1'b1, 12'h044, 32'hc, 4'hf);
		bad = 1'b0;
		repeat (3000) begin
			@(posedge clk_sys);
			if ({row_pin, col_pin} !== {DAC_IDLE, DAC_IDLE})
				bad = 1'b1;
		end
		`CHK(bad, 1'b0)
		wb(1'b1, 12'h044, 32'h0, 4'hf);
		$display("test disabled done");
		for (int i = 0; i < 4; i++)
			tone({2'(i), 2'(3 - i)}, 1'b1, 1);
		osc_fast <= 1'b1;
		wb(1'b1, 12'h080, 32'h4, 4'hf);
		tone(4'hc, 1'b0, 1);
		wb(1'b1, 12'h080, 32'h0, 4'hf);
		tone(4'hc, 1'b0, 2);
		wb(1'b1, 12'h080, 32'h4, 4'hf);
		wb(1'b1, 12'h044, 32'he, 4'hf);
		repeat (2000) @(posedge clk_sys);
		rst_b <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rst_b <= 1'b1;
		bad = 1'b0;
		repeat (3000) begin
			@(posedge clk_sys);
			if ({row_pin, col_pin} !== {DAC_IDLE, DAC_IDLE})
				bad = 1'b1;
		end
		`CHK(bad, 1'b0)
		wb(1'b0, 12'h080, 32'h0, 4'hf);
		`CHK(q, 32'h0)
		$display("test mid-run reset done");
		end_sim();
	end
endmodule
`default_nettype wire

//--- verilog/dtd_pkg.sv
// dtd_pkg: constants and tables for the dual-tone dialing generator
// Function
// RL1: tone_frequency_select bits 1:0 pick row tone 697/770/852/941 Hz.
// RL2: tone_frequency_select bits 3:2 pick column tone 1209/1336/1477/1633 Hz.
// RL3: tone_control is three-bit write-only, cleared to zero by reset.
// RL4: tone_control bit 1 enables the whole generator.
// RL5: tone_control bit 2 gates the row tone pin.
// RL6: tone_control bit 3 gates the column tone pin.
// RL7: tone_speed_flag is bit 2 at 020, set and cleared singly.
// RL8: same tones from 400 kHz core, or 800 kHz with speed flag set.
// RL9: each sine cycle has 32 equal time slots, one step each; the code splits len ticks into slots whose widths differ by up to one.
// RL10: row and column sines have separate converters and pins.
// RL11: actual cycle lengths give 694.44 ... 1639.34 Hz tones.
// RL12: tone_frequency_select is four-bit write-only, cleared by reset.
// RL13: master enable low holds both pins at idle level.
`default_nettype none
package dtd_pkg;
	localparam int          CLK_PERIOD_NS = 20;
	localparam logic [15:0] CLK_KHZ       = 16'(1000000 / CLK_PERIOD_NS);
	localparam logic [15:0] CORE_SLOW_KHZ = 16'd400;
	localparam logic [15:0] CORE_FAST_KHZ = 16'd800;
	localparam int          SLOTS         = 32;
	localparam int          SLOT_W        = 5;
	localparam int          LEN_W         = 10;
	localparam int          DAC_W         = 8;

	// register indices; byte address is four times the index
	localparam logic [9:0] IDX_FSEL   = 10'h010;
	localparam logic [9:0] IDX_CTRL   = 10'h011;
	localparam logic [9:0] IDX_SPEED  = 10'h020;
	localparam logic [9:0] IDX_STATUS = 10'h021;

	localparam int CTRL_EN_BIT  = 1;
	localparam int CTRL_ROW_BIT = 2;
	localparam int CTRL_COL_BIT = 3;
	localparam int SPEED_BIT    = 2;
	localparam int ST_ROW_RUN   = 10;
	localparam int ST_COL_RUN   = 11;
	localparam int ST_FAST      = 12;

	localparam logic [3:0] FSEL_RST  = 4'h0;
	localparam logic [2:0] CTRL_RST  = 3'h0;
	localparam logic       SPEED_RST = 1'b0;

	localparam logic [DAC_W-1:0] DAC_IDLE = 8'h80;

	typedef logic [LEN_W-1:0] dtd_len_t;

	// core clocks per sine cycle at 400 kHz
	localparam dtd_len_t ROW_LEN [4] = '{10'd576, 10'd520, 10'd470, 10'd426};
	localparam dtd_len_t COL_LEN [4] = '{10'd330, 10'd300, 10'd270, 10'd244};

	localparam logic [DAC_W-1:0] SINE [SLOTS] = '{
		8'h80, 8'h99, 8'hb1, 8'hc7, 8'hda, 8'hea, 8'hf5, 8'hfd,
		8'hff, 8'hfd, 8'hf5, 8'hea, 8'hda, 8'hc7, 8'hb1, 8'h99,
		8'h80, 8'h67, 8'h4f, 8'h39, 8'h26, 8'h16, 8'h0b, 8'h03,
		8'h01, 8'h03, 8'h0b, 8'h16, 8'h26, 8'h39, 8'h4f, 8'h67};
endpackage
`default_nettype wire

//--- verilog/dtd_tone_chan.sv
// dtd_tone_chan: one sine channel with fractional slot divider and converter code
`timescale 1ns/1ps
`default_nettype none
module dtd_tone_chan
	import dtd_pkg::*;
#(
	parameter dtd_len_t LEN [4] = ROW_LEN
) (
	input  wire logic              clk_sys, // system clock
	input  wire logic              rst_b,   // sync reset, active low
	input  wire logic              tick,    // 400 kHz tone-rate enable
	input  wire logic              run,     // channel enabled and gated on
	input  wire logic [1:0]        sel,     // frequency code
	output logic      [DAC_W-1:0]  dac_q,   // ladder converter code
	output logic      [SLOT_W-1:0] slot_q   // current time slot
);
	if (SLOTS != (1 << SLOT_W)) begin : g_bad_slots
		$error("slot count must be a power of two");
	end

	dtd_len_t          acc_q, acc_d, len;
	logic [SLOT_W-1:0] slot_d;
	logic [DAC_W-1:0]  dac_d;
	logic [LEN_W:0]    acc_sum;

	assign len = LEN[sel];

	// bresenham split: 32 slot steps over len ticks, slot widths differ by at most one
	always_comb begin
		acc_d   = acc_q;
		slot_d  = slot_q;
		acc_sum = {1'b0, acc_q} + (LEN_W + 1)'(SLOTS);
		dac_d   = SINE[slot_q]; // RL10
		if (!run) begin
			acc_d  = '0;
			slot_d = '0;
			dac_d  = DAC_IDLE; // RL13
		end else if (tick) begin
			if (acc_sum >= {1'b0, len}) begin // RL9
				acc_d  = LEN_W'(acc_sum - {1'b0, len});
				slot_d = slot_q + 1'b1;
			end else begin
				acc_d = acc_sum[LEN_W-1:0];
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			acc_q  <= '0;
			slot_q <= '0;
			dac_q  <= DAC_IDLE;
		end else begin
			acc_q  <= acc_d;
			slot_q <= slot_d;
			dac_q  <= dac_d;
		end
	end

	// helper: ticks per full sine cycle, void when the code changes mid-cycle
	dtd_len_t cnt_q;
	logic     dirty_q;
	logic     wrap;
	assign wrap = run && tick && (slot_d == '0) && (slot_q == '1);

	always_ff @(posedge clk_sys) begin
		if (!rst_b || !run || wrap) begin
			cnt_q   <= '0;
			dirty_q <= 1'b0;
		end else begin
			if (tick)
				cnt_q <= cnt_q + 1'b1;
			if (sel != $past(sel))
				dirty_q <= 1'b1;
		end
	end

	property p_cycle_len;
		@(posedge clk_sys) disable iff (!rst_b)
		(wrap && !dirty_q && $stable(sel)) |-> (LEN_W'(cnt_q + 1'b1) == len);
	endproperty
	a_cycle_len: assert property (p_cycle_len) // RL11
		else $error("sine cycle length differs from selected divider");

	a_slot_step: assert property (@(posedge clk_sys) disable iff (!rst_b) // RL9
		($past(run) && run && slot_q != $past(slot_q)) |-> slot_q == SLOT_W'($past(slot_q) + 1'b1))
		else $error("time slot skipped");

	a_dac_table: assert property (@(posedge clk_sys) disable iff (!rst_b) // RL10
		run |=> (!run || dac_q == SINE[$past(slot_q)]))
		else $error("converter code is not the sine step of the slot");

	c_wrap: cover property (@(posedge clk_sys) disable iff (!rst_b) wrap && !dirty_q);
endmodule
`default_nettype wire

//--- verilog/dtd_top.sv
// dtd_top: dual-tone dialing generator with wishbone register slave
`timescale 1ns/1ps
`default_nettype none
module dtd_top
	import dtd_pkg::*;
(
	input  wire logic              clk_sys,         // system clock, 50 MHz
	input  wire logic              rst_b,           // sync reset, active low
	input  wire logic              osc_fast_pin,    // core oscillator runs at 800 kHz
	input  wire logic              wb_cyc_i,        // wishbone cycle
	input  wire logic              wb_stb_i,        // wishbone strobe
	input  wire logic              wb_we_i,         // wishbone write enable
	input  wire logic [11:0]       wb_adr_i,        // wishbone byte address
	input  wire logic [3:0]        wb_sel_i,        // wishbone byte selects
	input  wire logic [31:0]       wb_dat_i,        // wishbone write data
	output logic      [31:0]       wb_dat_o,        // wishbone read data
	output logic                   wb_ack_o,        // wishbone acknowledge
	output logic      [DAC_W-1:0]  row_tone_pin,    // row converter code
	output logic      [DAC_W-1:0]  column_tone_pin  // column converter code
);
	// pin synchroniser for the oscillator speed strap
	logic sync1_q, sync2_q, sync3_q;
	logic fast_q, fast_d;

	always_comb begin
		fast_d = fast_q;
		if (sync2_q == sync3_q)
			fast_d = sync3_q;
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			sync3_q <= 1'b0;
			fast_q  <= 1'b0;
		end else begin
			sync1_q <= osc_fast_pin;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
			fast_q  <= fast_d;
		end
	end

	// core clock enable at 400 or 800 kHz, fractional divide of clk_sys
	logic [15:0] core_acc_q, core_acc_d;
	logic [16:0] core_sum;
	logic        core_tick_q, core_tick_d;

	always_comb begin
		core_sum    = {1'b0, core_acc_q} + {1'b0, (fast_q ? CORE_FAST_KHZ : CORE_SLOW_KHZ)};
		core_tick_d = 1'b0;
		core_acc_d  = core_sum[15:0];
		if (core_sum >= {1'b0, CLK_KHZ}) begin
			core_acc_d  = 16'(core_sum - {1'b0, CLK_KHZ});
			core_tick_d = 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			core_acc_q  <= '0;
			core_tick_q <= 1'b0;
		end else begin
			core_acc_q  <= core_acc_d;
			core_tick_q <= core_tick_d;
		end
	end

	// registers
	logic [3:0] fsel_q, fsel_d;
	logic [2:0] ctrl_q, ctrl_d;
	logic       speed_q, speed_d;
	logic       ack_q, ack_d;
	logic [31:0] rdat_q, rdat_d;
	logic        acc_go, wr_go;
	logic [9:0]  idx;
	logic [31:0] status;
	logic [SLOT_W-1:0] row_slot, col_slot;
	logic        gen_en, row_run, col_run;

	assign idx    = wb_adr_i[11:2];
	assign acc_go = wb_cyc_i && wb_stb_i && !ack_q;
	assign wr_go  = acc_go && wb_we_i && wb_sel_i[0];

	assign gen_en  = ctrl_q[CTRL_EN_BIT-1]; // RL4
	assign row_run = gen_en && ctrl_q[CTRL_ROW_BIT-1]; // RL5
	assign col_run = gen_en && ctrl_q[CTRL_COL_BIT-1]; // RL6

	always_comb begin
		status                      = '0;
		status[SLOT_W-1:0]          = row_slot;
		status[2*SLOT_W-1:SLOT_W]   = col_slot;
		status[ST_ROW_RUN]          = row_run;
		status[ST_COL_RUN]          = col_run;
		status[ST_FAST]             = fast_q;
	end

	always_comb begin
		fsel_d  = fsel_q;
		ctrl_d  = ctrl_q;
		speed_d = speed_q;
		ack_d   = acc_go;
		rdat_d  = '0;
		if (wr_go) begin
			case (idx)
				IDX_FSEL: fsel_d = wb_dat_i[3:0]; // RL12
				IDX_CTRL: ctrl_d = wb_dat_i[CTRL_COL_BIT:CTRL_EN_BIT]; // RL3
				IDX_SPEED: speed_d = wb_dat_i[SPEED_BIT]; // RL7
				default: ;
			endcase
		end
		if (acc_go && !wb_we_i) begin
			case (idx)
				IDX_SPEED: rdat_d[SPEED_BIT] = speed_q;
				IDX_STATUS: rdat_d = status;
				default: rdat_d = '0;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			fsel_q  <= FSEL_RST; // RL12
			ctrl_q  <= CTRL_RST; // RL3
			speed_q <= SPEED_RST;
			ack_q   <= 1'b0;
			rdat_q  <= '0;
		end else begin
			fsel_q  <= fsel_d;
			ctrl_q  <= ctrl_d;
			speed_q <= speed_d;
			ack_q   <= ack_d;
			rdat_q  <= rdat_d;
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;

	// tone-rate enable: with the speed flag, every other core tick
	logic half_q, half_d;
	logic tone_tick;

	assign tone_tick = core_tick_q && (!speed_q || half_q); // RL8

	always_comb begin
		half_d = half_q;
		if (!speed_q)
			half_d = 1'b0;
		else if (core_tick_q)
			half_d = !half_q;
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b)
			half_q <= 1'b0;
		else
			half_q <= half_d;
	end

	dtd_tone_chan #(
		.LEN (ROW_LEN)
	) u_row (
		.clk_sys (clk_sys),
		.rst_b   (rst_b),
		.tick    (tone_tick),
		.run     (row_run),
		.sel     (fsel_q[1:0]), // RL1
		.dac_q   (row_tone_pin),
		.slot_q  (row_slot)
	);

	dtd_tone_chan #(
		.LEN (COL_LEN)
	) u_col (
		.clk_sys (clk_sys),
		.rst_b   (rst_b),
		.tick    (tone_tick),
		.run     (col_run),
		.sel     (fsel_q[3:2]), // RL2
		.dac_q   (column_tone_pin),
		.slot_q  (col_slot)
	);

	// helper: core ticks since the last tone tick
	logic [1:0] since_q;
	always_ff @(posedge clk_sys) begin
		if (!rst_b || tone_tick)
			since_q <= '0;
		else if (core_tick_q && since_q != 2'h3)
			since_q <= since_q + 1'b1;
	end

	// helper: clocks since the last core tick, trusted once a full interval ran at one rate
	logic [7:0] gap_q;
	logic       gap_ok_q, gap_fast_q;
	always_ff @(posedge clk_sys) begin
		gap_fast_q <= fast_q;
		if (!rst_b || core_tick_q)
			gap_q <= '0;
		else if (gap_q != 8'hff)
			gap_q <= gap_q + 1'b1;
		if (!rst_b || fast_q != gap_fast_q)
			gap_ok_q <= 1'b0;
		else if (core_tick_q)
			gap_ok_q <= 1'b1;
	end

	a_idle_off: assert property (@(posedge clk_sys) disable iff (!rst_b) // RL13
		(!gen_en && $past(!gen_en)) |-> (row_tone_pin == DAC_IDLE && column_tone_pin == DAC_IDLE))
		else $error("tone pins not idle while generator disabled");

	a_row_gate: assert property (@(posedge clk_sys) disable iff (!rst_b) // RL5
		!row_run |=> row_tone_pin == DAC_IDLE)
		else $error("row pin moves while row output stopped");

	a_col_gate: assert property (@(posedge clk_sys) disable iff (!rst_b) // RL6
		!col_run |=> column_tone_pin == DAC_IDLE)
		else $error("column pin moves while column output stopped");

	a_reg_reset: assert property (@(posedge clk_sys) // RL3
		!rst_b |=> (ctrl_q == CTRL_RST && fsel_q == FSEL_RST && !wb_ack_o))
		else $error("registers not cleared by reset");

	a_fsel_write: assert property (@(posedge clk_sys) disable iff (!rst_b) // RL12
		(wr_go && idx == IDX_FSEL) |=> (fsel_q == $past(wb_dat_i[3:0]) && wb_ack_o))
		else $error("frequency select write lost");

	a_ctrl_write: assert property (@(posedge clk_sys) disable iff (!rst_b) // RL4
		(wr_go && idx == IDX_CTRL) |=> gen_en == $past(wb_dat_i[CTRL_EN_BIT]))
		else $error("enable bit write lost");

	a_speed_rw: assert property (@(posedge clk_sys) disable iff (!rst_b) // RL7
		(acc_go && !wb_we_i && idx == IDX_SPEED)
		|=> (wb_dat_o[SPEED_BIT] == $past(speed_q) && wb_ack_o))
		else $error("speed flag does not read back");

	a_speed_write: assert property (@(posedge clk_sys) disable iff (!rst_b) // RL7
		(wr_go && idx == IDX_SPEED) |=> speed_q == $past(wb_dat_i[SPEED_BIT]))
		else $error("speed flag write lost");

	a_gate_write: assert property (@(posedge clk_sys) disable iff (!rst_b) // RL5
		(wr_go && idx == IDX_CTRL) |=> ctrl_q == $past(wb_dat_i[CTRL_COL_BIT:CTRL_EN_BIT]))
		else $error("control bits write lost");

	a_sel_mask: assert property (@(posedge clk_sys) disable iff (!rst_b) // RL3
		(acc_go && wb_we_i && !wb_sel_i[0])
		|=> ($stable(ctrl_q) && $stable(fsel_q) && $stable(speed_q) && wb_ack_o))
		else $error("write without low byte select changed a register");

	a_fsel_hold: assert property (@(posedge clk_sys) disable iff (!rst_b) // RL12
		!(wr_go && idx == IDX_FSEL) |=> $stable(fsel_q))
		else $error("frequency select changed without a write");

	a_rdat_idle: assert property (@(posedge clk_sys) disable iff (!rst_b)
		!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data not zero outside acknowledge");

	a_status_read: assert property (@(posedge clk_sys) disable iff (!rst_b) // RL8
		(acc_go && !wb_we_i && idx == IDX_STATUS) |=> wb_dat_o[ST_FAST] == $past(fast_q))
		else $error("status does not show oscillator speed");

	a_fast_sync: assert property (@(posedge clk_sys) disable iff (!rst_b) // RL8
		(sync2_q == sync3_q) |=> fast_q == $past(sync3_q))
		else $error("oscillator strap not taken after agreement");

	a_half_clear: assert property (@(posedge clk_sys) disable iff (!rst_b) // RL8
		!speed_q |=> !half_q)
		else $error("half-rate phase kept with speed flag low");

	a_tick_slow: assert property (@(posedge clk_sys) disable iff (!rst_b) // RL8
		!speed_q |-> tone_tick == core_tick_q)
		else $error("tone tick skips core ticks with speed flag low");

	a_core_gap: assert property (@(posedge clk_sys) disable iff (!rst_b) // RL8
		(core_tick_q && gap_ok_q && fast_q == gap_fast_q)
		|-> (fast_q ? (gap_q == 8'd61 || gap_q == 8'd62) : gap_q == 8'd124))
		else $error("core tick spacing does not match oscillator rate");

	a_tone_rate: assert property (@(posedge clk_sys) disable iff (!rst_b) // RL8
		(tone_tick && $stable(speed_q) && $past(core_tick_q) == 1'b0)
		|-> (core_tick_q && (since_q == (speed_q ? 2'h1 : 2'h0) || since_q == 2'h3)))
		else $error("tone tick rate does not follow speed flag");

	a_ack_pulse: assert property (@(posedge clk_sys) disable iff (!rst_b)
		acc_go |=> wb_ack_o ##1 !wb_ack_o)
		else $error("acknowledge is not a single cycle");

	c_both_tones: cover property (@(posedge clk_sys) disable iff (!rst_b) row_run && col_run);
	c_row_only: cover property (@(posedge clk_sys) disable iff (!rst_b) row_run && !col_run);
	c_fast_core: cover property (@(posedge clk_sys) disable iff (!rst_b) speed_q && fast_q && tone_tick);
	c_status_read: cover property (@(posedge clk_sys) disable iff (!rst_b)
		acc_go && !wb_we_i && idx == IDX_STATUS);
endmodule
`default_nettype wire
